// ==== core/sia_route.sv ====
// Routing core: selector decode for inputs and output pin pairs
`timescale 1ns/100ps
module sia_route
    import sia_pkg::*;
(
    sia_route_if.core rt
);
    // Input function decode from selector digits
    always_comb
    begin
        logic [3:0] s;
        s = 4'h0;
        rt.ifunc = '0;
        for (int f = 0; f < NUM_IN_FUNCS; f++)
        begin
            s = rt.in_sel[f*4 +: 4];
            if (s <= SEL_PIN_LAST)
                rt.ifunc[f] = rt.pins[s[2:0]];
            else if (s >= SEL_INV_FIRST)
                rt.ifunc[f] = ~rt.pins[3'(s - SEL_INV_FIRST)];
            else if (s == SEL_ALWAYS_ON)
                rt.ifunc[f] = 1'b1;
            else
                rt.ifunc[f] = 1'b0;
        end
    end

    // Output pair build: OR of selected functions, then inversion
    always_comb
    begin
        logic [3:0] s;
        logic [NUM_OUT_PAIRS-1:0] acc;
        s = 4'h0;
        acc = '0;
        for (int f = 0; f < NUM_OUT_FUNCS; f++)
        begin
            s = rt.out_sel[f*4 +: 4];
            if (s != SEL_OUT_NONE && s <= 4'(NUM_OUT_PAIRS))
                acc[2'(s - 4'h1)] = acc[2'(s - 4'h1)] | rt.ofunc[f];
        end
        rt.pairs = acc ^ rt.pol_inv;
    end
endmodule

// ==== core/sia_top.sv ====
// Top: APB registers, pin synchronisers and registered pin outputs
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module sia_top
(
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [11:0]                       paddr,
    input  wire logic [31:0]                       pwdata,
    input  wire logic [3:0]                        pstrb,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic [sia_pkg::NUM_IN_PINS-1:0]   in_pins,
    input  wire logic [sia_pkg::NUM_OUT_FUNCS-1:0] out_func,
    output logic      [sia_pkg::NUM_OUT_PAIRS-1:0] out_pairs,
    output logic      [sia_pkg::NUM_IN_FUNCS-1:0]  in_func
);
    import sia_pkg::*;

    sia_route_if rt ();                         // Routing bundle

    logic [31:0] in_lo_q,  in_lo_d;             // Input selectors 0-7
    logic [31:0] in_hi_q,  in_hi_d;             // Input selector 8
    logic [31:0] out_lo_q, out_lo_d;            // Output selectors 0-7
    logic [31:0] out_hi_q, out_hi_d;            // Output selector 8
    logic [2:0]  pol_q,    pol_d;               // Pair inversion
    sia_mode_t   mode_q,   mode_d;              // Active control mode
    logic [31:0] rdata_q,  rdata_d;             // Read data
    logic        rdy_q,    rdy_d;               // Access answer
    logic        err_q,    err_d;               // Error answer
    logic [NUM_IN_PINS-1:0]   sync1_q, sync2_q; // Pin synchroniser
    logic [NUM_OUT_PAIRS-1:0] pairs_q;          // Registered pair levels
    logic [NUM_IN_FUNCS-1:0]  ifunc_q;          // Registered inputs
    logic [NUM_OUT_FUNCS-1:0] omask;            // Mode-evaluated outputs
    logic [NUM_IN_FUNCS*4-1:0] in_sel_w;        // Flattened selectors
    logic        access, wr, bad;               // Bus decode
    logic [31:0] wmask;                         // Byte lane mask

    // Latch selectors: reject codes outside 4-8 and D-F
    function automatic logic latch_ok(input logic [3:0] s);
        return (s >= SEL_LATCH_LO && s <= SEL_LATCH_HI) ||
               s >= SEL_LATCH_ILO || s == SEL_ALWAYS_ON ||
               s == SEL_ALWAYS_OFF;
    endfunction

    // Pin synchroniser, two stages
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= in_pins;
            sync2_q <= sync1_q;
        end
    end

    // APB decode and register next values
    always_comb
    begin
        access   = psel && penable;
        wr       = access && pwrite;
        wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}},
                    {8{pstrb[1]}}, {8{pstrb[0]}}};
        in_lo_d  = in_lo_q;
        in_hi_d  = in_hi_q;
        out_lo_d = out_lo_q;
        out_hi_d = out_hi_q;
        pol_d    = pol_q;
        mode_d   = mode_q;
        rdata_d  = rdata_q;
        bad      = 1'b0;
        case (paddr)
            ADDR_IN_SEL_LO:  rdata_d = in_lo_q;
            ADDR_IN_SEL_HI:  rdata_d = in_hi_q;
            ADDR_OUT_SEL_LO: rdata_d = out_lo_q;
            ADDR_OUT_SEL_HI: rdata_d = out_hi_q;
            ADDR_POLARITY:   rdata_d = {29'h0, pol_q};
            ADDR_MODE:       rdata_d = {30'h0, mode_q};
            ADDR_STATUS:     rdata_d = {13'h0, pairs_q, 7'h0, ifunc_q};
            default:         bad = 1'b1;
        endcase
        if (wr && !bad)
        begin
            case (paddr)
                ADDR_IN_SEL_LO:
                begin
                    in_lo_d = (in_lo_q & ~wmask) | (pwdata & wmask);
                    for (int f = IF_LATCH1; f <= 7; f++)
                        if (!latch_ok(in_lo_d[f*4 +: 4]))
                            in_lo_d[f*4 +: 4] = in_lo_q[f*4 +: 4];
                end
                ADDR_IN_SEL_HI:
                    in_hi_d = ((in_hi_q & ~wmask) | (pwdata & wmask))
                              & 32'h0000_000f;
                ADDR_OUT_SEL_LO:
                    out_lo_d = (out_lo_q & ~wmask) | (pwdata & wmask);
                ADDR_OUT_SEL_HI:
                    out_hi_d = ((out_hi_q & ~wmask) | (pwdata & wmask))
                               & 32'h0000_000f;
                ADDR_POLARITY:
                    if (pstrb[0]) pol_d = pwdata[2:0];
                ADDR_MODE:
                    if (pstrb[0] && pwdata[1:0] != 2'h3)
                        mode_d = sia_mode_t'(pwdata[1:0]);
                default:
                    bad = 1'b1;
            endcase
        end
        rdy_d = access && !rdy_q;
        err_d = access && !rdy_q && bad;
        if (!(access && !rdy_q))
            rdata_d = '0;
        else if (pwrite)
            rdata_d = '0;
        // Writes commit only at the edge where pready is seen high
        if (!(access && rdy_q))
        begin
            in_lo_d  = in_lo_q;
            in_hi_d  = in_hi_q;
            out_lo_d = out_lo_q;
            out_hi_d = out_hi_q;
            pol_d    = pol_q;
            mode_d   = mode_q;
        end
    end

    // Register state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_lo_q  <= RST_IN_SEL_LO;
            in_hi_q  <= RST_IN_SEL_HI;
            out_lo_q <= RST_OUT_SEL_LO;
            out_hi_q <= RST_OUT_SEL_HI;
            pol_q    <= RST_POLARITY;
            mode_q   <= SIA_MODE_POS;
            rdata_q  <= '0;
            rdy_q    <= 1'b0;
            err_q    <= 1'b0;
        end
        else
        begin
            in_lo_q  <= in_lo_d;
            in_hi_q  <= in_hi_d;
            out_lo_q <= out_lo_d;
            out_hi_q <= out_hi_d;
            pol_q    <= pol_d;
            mode_q   <= mode_d;
            rdata_q  <= rdata_d;
            rdy_q    <= rdy_d;
            err_q    <= err_d;
        end
    end

    // Mode mask of evaluated output functions
    always_comb
    begin
        omask = '1;
        case (mode_q)
            SIA_MODE_POS:
                omask[OF_SPD_MATCH] = 1'b0;
            SIA_MODE_SPEED:
            begin
                omask[OF_POS_DONE] = 1'b0;
                omask[OF_NEAR]     = 1'b0;
            end
            SIA_MODE_TORQUE:
            begin
                omask[OF_POS_DONE]  = 1'b0;
                omask[OF_NEAR]      = 1'b0;
                omask[OF_SPD_MATCH] = 1'b0;
            end
            default:
                omask = '1;
        endcase
    end

    assign in_sel_w   = {in_hi_q[3:0], in_lo_q};
    assign rt.in_sel  = in_sel_w;
    assign rt.out_sel = {out_hi_q[3:0], out_lo_q};
    assign rt.pol_inv = pol_q;
    assign rt.pins    = sync2_q;
    assign rt.ofunc   = out_func & omask;

    sia_route u_route (
        .rt (rt)
    );

    // Registered routed outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pairs_q <= '0;
            ifunc_q <= '0;
        end
        else
        begin
            pairs_q <= rt.pairs;
            ifunc_q <= rt.ifunc;
        end
    end

    assign prdata    = rdata_q;
    assign pready    = rdy_q;
    assign pslverr   = err_q;
    assign out_pairs = pairs_q;
    assign in_func   = ifunc_q;

    // Inactive functions never reach the pairs
    property p_mode_gate;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == SIA_MODE_SPEED && out_lo_q[31:4] == 28'h0
         && out_hi_q[3:0] == 4'h0)
        |=> (pairs_q == $past(pol_q));
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("Masked output reached a pair");

    // Fixed-on code yields high one cycle later
    property p_always_on;
        @(posedge pclk) disable iff (!presetn)
        (in_lo_q[11:8] == SEL_ALWAYS_ON) |=> ifunc_q[IF_FWD_CLAMP];
    endproperty
    a_always_on: assert property (p_always_on)
        else $error("Always-on input not asserted");

    // Fixed-off code yields low
    property p_always_off;
        @(posedge pclk) disable iff (!presetn)
        (in_lo_q[11:8] == SEL_ALWAYS_OFF) |=> !ifunc_q[IF_FWD_CLAMP];
    endproperty
    a_always_off: assert property (p_always_off)
        else $error("Always-off input asserted");

    // Direct code follows the synchronised pin
    property p_direct;
        @(posedge pclk) disable iff (!presetn)
        (in_lo_q[7:4] <= SEL_PIN_LAST)
        |=> ifunc_q[IF_REV_LIMIT] == $past(sync2_q[in_lo_q[6:4]]);
    endproperty
    a_direct: assert property (p_direct)
        else $error("Direct input code misrouted");

    // Latch fields stay legal
    property p_latch_legal;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |-> latch_ok(in_lo_q[23:20]) && latch_ok(in_lo_q[27:24])
                 && latch_ok(in_lo_q[31:28]);
    endproperty
    a_latch_legal: assert property (p_latch_legal)
        else $error("Latch selector holds a forbidden pin");

    // Two functions on one pin agree
    property p_shared_pin;
        @(posedge pclk) disable iff (!presetn)
        (in_lo_q[3:0] == in_lo_q[11:8]) |=>
        ifunc_q[IF_FWD_LIMIT] == ifunc_q[IF_FWD_CLAMP];
    endproperty
    a_shared_pin: assert property (p_shared_pin)
        else $error("Shared pin gave different levels");

    // Ready and brake alone on pair 1: pair is their OR, then inversion
    property p_brake_pair;
        @(posedge pclk) disable iff (!presetn)
        (out_lo_q == 32'h0100_1000 && out_hi_q[3:0] == 4'h0)
        |=> pairs_q[0] == (($past(out_func[OF_BRAKE])
                            | $past(out_func[OF_READY]))
                           ^ $past(pol_q[0]));
    endproperty
    a_brake_pair: assert property (p_brake_pair)
        else $error("Pair driven without a source");

    // APB answers one cycle after access begins
    property p_apb_ready;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("APB answer timing wrong");
endmodule

// ==== inc/sia_pkg.sv ====
// Package: constants and types of the servo I/O signal allocation block
package sia_pkg;
    // Number of sequence input pins, output pin pairs, input functions and output functions
    localparam int NUM_IN_PINS   = 7;
    localparam int NUM_OUT_PAIRS = 3;
    localparam int NUM_IN_FUNCS  = 9;
    localparam int NUM_OUT_FUNCS = 9;
    // Input selector codes
    localparam logic [3:0] SEL_PIN_LAST   = 4'h6;
    localparam logic [3:0] SEL_ALWAYS_ON  = 4'h7;
    localparam logic [3:0] SEL_ALWAYS_OFF = 4'h8;
    localparam logic [3:0] SEL_INV_FIRST  = 4'h9;
    localparam logic [3:0] SEL_LATCH_LO   = 4'h4;
    localparam logic [3:0] SEL_LATCH_HI   = 4'h6;
    localparam logic [3:0] SEL_LATCH_ILO  = 4'hd;
    // Output selector code for unconnected
    localparam logic [3:0] SEL_OUT_NONE = 4'h0;
    // Input function indices
    localparam int IF_FWD_LIMIT = 0;
    localparam int IF_REV_LIMIT = 1;
    localparam int IF_FWD_CLAMP = 2;
    localparam int IF_REV_CLAMP = 3;
    localparam int IF_SLOWDOWN  = 4;
    localparam int IF_LATCH1    = 5;
    localparam int IF_LATCH2    = 6;
    localparam int IF_LATCH3    = 7;
    localparam int IF_DB_ANSWER = 8;
    // Output function indices
    localparam int OF_POS_DONE  = 0;
    localparam int OF_SPD_MATCH = 1;
    localparam int OF_ROTATING  = 2;
    localparam int OF_READY     = 3;
    localparam int OF_TRQ_LIM   = 4;
    localparam int OF_SPD_LIM   = 5;
    localparam int OF_BRAKE     = 6;
    localparam int OF_WARN      = 7;
    localparam int OF_NEAR      = 8;
    // Register byte addresses
    localparam logic [11:0] ADDR_IN_SEL_LO  = 12'h000;
    localparam logic [11:0] ADDR_IN_SEL_HI  = 12'h004;
    localparam logic [11:0] ADDR_OUT_SEL_LO = 12'h008;
    localparam logic [11:0] ADDR_OUT_SEL_HI = 12'h00c;
    localparam logic [11:0] ADDR_POLARITY   = 12'h010;
    localparam logic [11:0] ADDR_MODE       = 12'h014;
    localparam logic [11:0] ADDR_STATUS     = 12'h018;
    // Reset values of the selector and polarity registers
    localparam logic [31:0] RST_IN_SEL_LO  = 32'h6543_2010;
    localparam logic [31:0] RST_IN_SEL_HI  = 32'h0000_0008;
    localparam logic [31:0] RST_OUT_SEL_LO = 32'h0000_0000;
    localparam logic [31:0] RST_OUT_SEL_HI = 32'h0000_0000;
    localparam logic [2:0]  RST_POLARITY   = 3'h0;
    // Control modes
    typedef enum logic [1:0] {
        SIA_MODE_POS,
        SIA_MODE_SPEED,
        SIA_MODE_TORQUE
    } sia_mode_t;
endpackage

// ==== inc/sia_route_if.sv ====
// Interface: routing fields passed from the top to the routing core
`timescale 1ns/100ps
interface sia_route_if;
    import sia_pkg::*;
    logic [NUM_IN_FUNCS*4-1:0]  in_sel;   // Input selectors
    logic [NUM_OUT_FUNCS*4-1:0] out_sel;  // Output selectors
    logic [NUM_OUT_PAIRS-1:0]   pol_inv;  // Pair polarity inversion
    logic [NUM_IN_PINS-1:0]     pins;     // Synchronised pin levels
    logic [NUM_OUT_FUNCS-1:0]   ofunc;    // Masked output function states
    logic [NUM_IN_FUNCS-1:0]    ifunc;    // Routed input functions
    logic [NUM_OUT_PAIRS-1:0]   pairs;    // Driven pair levels
    modport top  (output in_sel, out_sel, pol_inv, pins, ofunc,
                  input ifunc, pairs);
    modport core (input in_sel, out_sel, pol_inv, pins, ofunc,
                  output ifunc, pairs);
endinterface

// ==== tb/sia_host_model.sv ====
// Host wiring model: drives the sequence input pins, sees output pairs
`timescale 1ns/100ps
module sia_host_model
    import sia_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic [NUM_OUT_PAIRS-1:0] out_pairs,
    output logic      [NUM_IN_PINS-1:0]   in_pins
);
    import sia_pkg::*;
    // Contact levels as wired; all open at start
    logic [NUM_IN_PINS-1:0] level_q = 7'h00;
    // Pins always show the contact levels, never left floating
    assign in_pins = level_q;
    // Contacts change just after a clock edge, like a relay bank would
    task automatic set_pins(input logic [NUM_IN_PINS-1:0] lv);
        @(posedge pclk);
        level_q <= lv;
    endtask
endmodule

// ==== tb/test_servo_io_signal_allocation.sv ====
// Testbench: APB set-up of pin routing with checks at the pins
`timescale 1ns/100ps
module test_servo_io_signal_allocation;
    import sia_pkg::*;
    // Output selector word: pairs 1,2,1,3,2,1,3,none for fn0..7
    localparam logic [31:0] OUT_LO = 32'h0312_3121;
    logic        pclk;           // Bus clock
    logic        presetn;        // Reset, active low
    logic        psel;           // APB select
    logic        penable;        // APB enable
    logic        pwrite;         // APB direction
    logic [11:0] paddr;          // APB address
    logic [31:0] pwdata;         // APB write data
    logic [3:0]  pstrb;          // APB byte lanes
    logic [31:0] prdata;         // APB read data
    logic        pready;         // APB ready
    logic        pslverr;        // APB error
    logic [6:0]  in_pins;        // Pins from the host model
    logic [8:0]  out_func;       // Output function states
    logic [2:0]  out_pairs;      // Pair levels
    logic [8:0]  in_func;        // Routed input functions
    logic [31:0] lo;             // Expected input selector word
    logic [31:0] ol;             // Output selector word applied
    logic [3:0]  hi;             // Expected fn8 selector
    logic [6:0]  pins;           // Pin levels applied
    logic [8:0]  fn;             // Output functions applied
    logic [1:0]  md;             // Mode applied
    logic [2:0]  ep;             // Expected pair levels
    logic [31:0] rdata;          // Read data taken
    logic        err;            // Error response taken
    int          failures;       // Mismatch count
    int          n_compared;     // Comparison count

    // Clock at 125 MHz
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    sia_top DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_pins(in_pins), .out_func(out_func), .out_pairs(out_pairs),
        .in_func(in_func)
    );

    sia_host_model HOST (
        .pclk(pclk), .out_pairs(out_pairs), .in_pins(in_pins)
    );

    // Verdict and end of run
    task automatic results();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        // A slave that never answers ends the run
        if (i == 20)
        begin
            failures++;
            results();
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Read a register and compare it
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask

    // Routed input functions expected from selectors and pins
    function automatic logic [8:0] exp_in(logic [31:0] l, logic [3:0] h,
                                          logic [6:0] p);
        logic [3:0] c;
        logic [8:0] r;
        for (int f = 0; f < 9; f++)
        begin
            c = (f < 8) ? l[4*f +: 4] : h;
            if (c <= 4'h6)
                r[f] = p[c];
            else if (c == 4'h7)
                r[f] = 1'b1;
            else if (c == 4'h8)
                r[f] = 1'b0;
            else
                r[f] = ~p[c - 4'h9];
        end
        return r;
    endfunction

    // Pair levels expected: mode mask, OR per pair, then inversion
    function automatic logic [2:0] exp_out(logic [31:0] l, logic [3:0] h,
        logic [8:0] v, logic [1:0] m, logic [2:0] pol);
        logic [3:0] c;
        logic [2:0] r;
        r = 3'h0;
        if (m != 2'h0)
        begin
            v[OF_POS_DONE] = 1'b0;
            v[OF_NEAR] = 1'b0;
        end
        if (m != 2'h1)
            v[OF_SPD_MATCH] = 1'b0;
        for (int f = 0; f < 9; f++)
        begin
            c = (f < 8) ? l[4*f +: 4] : h;
            if (c >= 4'h1 && c <= 4'h3)
                r[c - 4'h1] = r[c - 4'h1] | v[f];
        end
        return r ^ pol;
    endfunction

    // Main sequence
    initial
    begin
        failures = 0;
        n_compared = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        out_func = 9'h000;
        hi = 4'h8;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of the selectors and polarity, pair levels, then an unmapped address
        rdchk(ADDR_IN_SEL_LO, RST_IN_SEL_LO);
        rdchk(ADDR_IN_SEL_HI, RST_IN_SEL_HI);
        rdchk(ADDR_OUT_SEL_LO, RST_OUT_SEL_LO);
        rdchk(ADDR_OUT_SEL_HI, RST_OUT_SEL_HI);
        rdchk(ADDR_POLARITY, 32'h0);
        check({29'h0, out_pairs}, 32'h0);
        apb(1'b0, 12'h01c, 32'h0);
        check({31'h0, err}, 32'h1);
        // Every code of the forward clamp field, both pin levels
        for (int c = 0; c < 16; c++)
        begin
            // travel-limit fields keep their default codes
            lo = RST_IN_SEL_LO;
            lo[11:8] = c[3:0];
            wr(ADDR_IN_SEL_LO, lo);
            for (int k = 0; k < 2; k++)
            begin
                pins = (k == 0) ? 7'h35 : 7'h4a;
                HOST.set_pins(pins);
                repeat (4) @(posedge pclk);
                check({23'h0, in_func}, {23'h0, exp_in(lo, hi, pins)});
            end
        end
        // Latch input: inverted code taken, low-pin code refused
        lo = RST_IN_SEL_LO;
        lo[23:20] = 4'hd;
        wr(ADDR_IN_SEL_LO, lo);
        wr(ADDR_IN_SEL_LO, {lo[31:24], 4'h2, lo[19:0]});
        rdchk(ADDR_IN_SEL_LO, lo);
        hi = 4'h7;
        wr(ADDR_IN_SEL_HI, 32'h7);
        pins = 7'h50;
        HOST.set_pins(pins);
        repeat (4) @(posedge pclk);
        check({23'h0, in_func}, {23'h0, exp_in(lo, hi, pins)});
        // Output routing over modes, inversions and function patterns
        wr(ADDR_OUT_SEL_LO, OUT_LO);
        wr(ADDR_OUT_SEL_HI, 32'h2);
        for (int s = 0; s < 8; s++)
        begin
            md = 2'(s % 3);
            wr(ADDR_MODE, {30'h0, md});
            wr(ADDR_POLARITY, {29'h0, 3'(s)});
            for (int f = 0; f < 11; f++)
            begin
                fn = (f < 9) ? (9'h1 << f) : ((f == 9) ? 9'h1ff : 9'h0);
                @(posedge pclk);
                out_func <= fn;
                repeat (2) @(posedge pclk);
                ep = exp_out(OUT_LO, 4'h2, fn, md, 3'(s));
                check({29'h0, out_pairs}, {29'h0, ep});
            end
        end
        // Undefined mode is ignored
        wr(ADDR_MODE, 32'h3);
        rdchk(ADDR_MODE, {30'h0, md});
        // Status word mirrors routed inputs and pair levels
        rdchk(ADDR_STATUS, {13'h0, ep, 7'h0, exp_in(lo, hi, pins)});
        // Ready and brake share pair 1; positioning alone in speed mode
        wr(ADDR_OUT_SEL_HI, 32'h0);
        for (int s = 0; s < 4; s++)
        begin
            ol = (s < 2) ? 32'h0100_1000 : 32'h0000_0001;
            md = (s < 2) ? 2'h0 : 2'h1;
            wr(ADDR_OUT_SEL_LO, ol);
            wr(ADDR_MODE, {30'h0, md});
            wr(ADDR_POLARITY, {31'h0, s[0]});
            for (int f = 0; f < 4; f++)
            begin
                fn = {2'h0, f[1], 2'h0, f[0], 2'h0, 1'b1};
                @(posedge pclk);
                out_func <= fn;
                repeat (2) @(posedge pclk);
                ep = exp_out(ol, 4'h0, fn, md, {2'h0, s[0]});
                check({29'h0, out_pairs}, {29'h0, ep});
            end
        end
        results();
    end
endmodule
